// ==== hw/lptt_top.sv ====
/*
  Low power tick timer: 16-bit timer on the 32 kHz clock, compare tick with
  early wake request, dual capture, AHB-Lite register slave, interrupt.
  Assumes one AHB-Lite master, lf_clk_pin and radio_irq_pin asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none

module lptt_top
  import lptt_pkg::*;
#(
  parameter int FINE_W = 9
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic lf_clk_pin,
  input wire logic radio_irq_pin,
  output logic tick_o,
  output logic wake_o,
  output logic irq_o
);

  if (FINE_W < 2 || FINE_W > 16)
  begin : g_chk
    $error("lptt_top: FINE_W must lie in 2..16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, one per pin
  logic [1:0] pin_in;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] sync3_reg;
  assign pin_in = {radio_irq_pin, lf_clk_pin};

  for (genvar i = 0; i < 2; i++)
  begin : g_sync
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        sync1_reg[i] <= 1'b0;
        sync2_reg[i] <= 1'b0;
        sync3_reg[i] <= 1'b0;
      end
      else
      begin
        sync1_reg[i] <= pin_in[i];
        sync2_reg[i] <= sync1_reg[i];
        sync3_reg[i] <= sync2_reg[i];
      end
    end
  end

  logic lf_rise;
  logic radio_rise;
  assign lf_rise = sync2_reg[0] & ~sync3_reg[0];
  assign radio_rise = sync2_reg[1] & ~sync3_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: writes take no wait, reads take one so data is current
  lptt_bus_e bus_reg, bus_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] idx_reg, idx_next;
  logic hit_reg, hit_next;
  logic hreadyout_reg, hreadyout_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [31:0] rd_mux;
  logic acc;
  logic acc_hit;

  lptt_cfg_s cfg_reg, cfg_next;
  lptt_irq_s status_reg, status_next, irq_en_reg, irq_en_next;
  logic [7:0] cmp_lo_reg, cmp_lo_next, cmp_hi_reg, cmp_hi_next;
  logic [15:0] cpt_slow_reg, cpt_slow_next;
  logic [7:0] cpt_fine_reg, cpt_fine_next;

  assign acc = hsel & htrans[1] & hready;
  assign acc_hit = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (hit_reg)
    begin
      case (idx_reg)
        IDX_CPT_SLOW_HIGH: rd_mux = {24'h000000, cpt_slow_reg[15:8]};
        IDX_CPT_FINE: rd_mux = {24'h000000, cpt_fine_reg};
        // trigger bit reads back as zero
        IDX_CONFIG: rd_mux = {28'h0000000, cfg_reg};
        IDX_CMP_LOW: rd_mux = {24'h000000, cmp_lo_reg};
        IDX_CMP_HIGH: rd_mux = {24'h000000, cmp_hi_reg};
        IDX_CPT_SLOW_LOW: rd_mux = {24'h000000, cpt_slow_reg[7:0]};
        IDX_IRQ_STATUS: rd_mux = {30'h00000000, status_reg};
        IDX_IRQ_ENABLE: rd_mux = {30'h00000000, irq_en_reg};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  always_comb
  begin
    bus_next = bus_reg;
    wr_pend_next = 1'b0;
    idx_next = idx_reg;
    hit_next = hit_reg;
    hreadyout_next = 1'b1;
    hrdata_next = hrdata_reg;
    case (bus_reg)
      BUS_IDLE:
      begin
        if (acc)
        begin
          idx_next = haddr[9:2];
          hit_next = acc_hit;
          wr_pend_next = hwrite;
          if (!hwrite)
          begin
            bus_next = BUS_RDWAIT;
            hreadyout_next = 1'b0;
          end
        end
      end
      BUS_RDWAIT:
      begin
        hrdata_next = rd_mux;
        bus_next = BUS_IDLE;
      end
      default: bus_next = BUS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_reg <= BUS_IDLE;
      wr_pend_reg <= 1'b0;
      idx_reg <= 8'h00;
      hit_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h00000000;
    end
    else
    begin
      bus_reg <= bus_next;
      wr_pend_reg <= wr_pend_next;
      idx_reg <= idx_next;
      hit_reg <= hit_next;
      hreadyout_reg <= hreadyout_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hrdata = hrdata_reg;
  assign hresp = 1'b0;

  logic wr_ok;
  assign wr_ok = wr_pend_reg & hit_reg;

  ////////////////////////////////////////////////////////////////////////////
  // timer core, fine counter, capture, tick and wake
  logic [15:0] timer_reg, timer_next;
  logic [FINE_W-1:0] fine_reg, fine_next;
  logic [15:0] cmp_val;
  logic [15:0] timer_inc;
  logic [15:0] precmp;
  logic sw_cap, cap_now, cmp_on, tick_start;
  logic wake_reg, wake_next, tick_reg, tick_next;
  logic [15:0] tick_cnt_reg, tick_cnt_next;
  logic irq_reg, irq_next;
  lptt_irq_s clr;

  assign cmp_val = {cmp_hi_reg, cmp_lo_reg};
  assign timer_inc = timer_reg + 16'h0001;
  // internal pre-compare value: one count ahead of the match
  assign precmp = cmp_val - 16'h0001;
  assign cmp_on = cfg_reg.mode[1];
  assign sw_cap = wr_ok && (idx_reg == IDX_CONFIG) && hwdata[CFG_SWCAP_BIT];
  assign cap_now = cfg_reg.en & (sw_cap | (cfg_reg.radio_en & radio_rise));
  // tick only with compare on, and only after wake is up
  assign tick_start = cfg_reg.en & lf_rise & cmp_on & wake_reg & (timer_next == cmp_val);
  assign clr = (wr_ok && idx_reg == IDX_IRQ_CLEAR) ? lptt_irq_s'(hwdata[1:0]) : 2'h0;

  always_comb
  begin
    cfg_next = cfg_reg;
    cmp_lo_next = cmp_lo_reg;
    cmp_hi_next = cmp_hi_reg;
    irq_en_next = irq_en_reg;
    if (wr_ok)
    begin
      case (idx_reg)
        IDX_CONFIG: cfg_next = lptt_cfg_s'(hwdata[CFG_RADIO_BIT:CFG_EN_BIT]);
        IDX_CMP_LOW: cmp_lo_next = hwdata[7:0];
        IDX_CMP_HIGH: cmp_hi_next = hwdata[7:0];
        IDX_IRQ_ENABLE: irq_en_next = lptt_irq_s'(hwdata[1:0]);
        default: cfg_next = cfg_reg;
      endcase
    end
    timer_next = timer_reg;
    // one count per 32 kHz edge, so a count is one period
    if (cfg_reg.en && lf_rise)
    begin
      // match clears timer in mode 11
      if (cfg_reg.mode == MODE_CLEAR && timer_reg == cmp_val)
        timer_next = 16'h0000;
      else
        timer_next = timer_inc;
    end
    // cycles since last lf edge; saturates instead of wrapping
    if (lf_rise)
      fine_next = '0;
    else if (fine_reg != {FINE_W{1'b1}})
      fine_next = fine_reg + 1'b1;
    else
      fine_next = fine_reg;
    cpt_slow_next = cpt_slow_reg;
    cpt_fine_next = cpt_fine_reg;
    if (cap_now)
    begin
      cpt_slow_next = timer_reg;
      cpt_fine_next = 8'(fine_reg[FINE_W-1:1]);
    end
    // wake one count ahead of the match
    wake_next = wake_reg;
    if (!cfg_reg.en || !cmp_on)
      wake_next = 1'b0;
    else if (lf_rise && timer_next == precmp)
      wake_next = 1'b1;
    else if (tick_reg && tick_cnt_reg == 16'h0001)
      wake_next = 1'b0;
    // tick lasts half an lf period
    tick_cnt_next = tick_cnt_reg;
    // a stale count must not revive the tick after re-enable
    if (!cfg_reg.en)
      tick_cnt_next = 16'h0000;
    else if (tick_start)
      tick_cnt_next = 16'(TICK_CYC);
    else if (tick_cnt_reg != 16'h0000)
      tick_cnt_next = tick_cnt_reg - 16'h0001;
    tick_next = cfg_reg.en && (tick_start || tick_cnt_reg > 16'h0001);
    // set wins over clear
    status_next = lptt_irq_s'((status_reg & ~clr) | {cap_now, tick_start});
    irq_next = |(status_reg & irq_en_reg);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_reg <= '0;
      cmp_lo_reg <= CMP_RESET;
      cmp_hi_reg <= CMP_RESET;
      irq_en_reg <= '0;
      status_reg <= '0;
      timer_reg <= 16'h0000;
      fine_reg <= '0;
      cpt_slow_reg <= {CPT_RESET, CPT_RESET};
      cpt_fine_reg <= CPT_RESET;
      wake_reg <= 1'b0;
      tick_reg <= 1'b0;
      tick_cnt_reg <= 16'h0000;
      irq_reg <= 1'b0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      cmp_lo_reg <= cmp_lo_next;
      cmp_hi_reg <= cmp_hi_next;
      irq_en_reg <= irq_en_next;
      status_reg <= status_next;
      timer_reg <= timer_next;
      fine_reg <= fine_next;
      cpt_slow_reg <= cpt_slow_next;
      cpt_fine_reg <= cpt_fine_next;
      wake_reg <= wake_next;
      tick_reg <= tick_next;
      tick_cnt_reg <= tick_cnt_next;
      irq_reg <= irq_next;
    end
  end

  assign tick_o = tick_reg;
  assign wake_o = wake_reg;
  assign irq_o = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_cap_both;
    @(posedge hclk) disable iff (!hresetn)
    cap_now |=> (cpt_slow_reg == $past(timer_reg)) && (cpt_fine_reg == 8'($past(fine_reg) >> 1));
  endproperty
  a_cap_both: assert property (p_cap_both) else $error("capture pair wrong");

  property p_sw_cap;
    @(posedge hclk) disable iff (!hresetn)
    (sw_cap && cfg_reg.en) |=> cpt_slow_reg == $past(timer_reg);
  endproperty
  a_sw_cap: assert property (p_sw_cap) else $error("software capture missed");

  property p_fine_zero;
    @(posedge hclk) disable iff (!hresetn)
    lf_rise ##1 !lf_rise [*2] |-> fine_reg == FINE_W'(1);
  endproperty
  a_fine_zero: assert property (p_fine_zero) else $error("fine count not from edge");

  property p_radio_off;
    @(posedge hclk) disable iff (!hresetn)
    (radio_rise && !cfg_reg.radio_en && !sw_cap) |=> $stable(cpt_slow_reg) && $stable(cpt_fine_reg);
  endproperty
  a_radio_off: assert property (p_radio_off) else $error("radio capture while off");

  property p_mode_off;
    @(posedge hclk) disable iff (!hresetn)
    !cfg_reg.mode[1] |=> !$rose(tick_reg);
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("tick with compare off");

  property p_clear;
    @(posedge hclk) disable iff (!hresetn)
    (cfg_reg.en && lf_rise && cfg_reg.mode == MODE_CLEAR && timer_reg == cmp_val) |=> timer_reg == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("timer not cleared on match");

  property p_tick_len;
    @(posedge hclk) disable iff (!hresetn)
    $rose(tick_reg) && cfg_reg.en |-> tick_reg [*8];
  endproperty
  a_tick_len: assert property (p_tick_len) else $error("tick too short");

  property p_wrap;
    @(posedge hclk) disable iff (!hresetn)
    (cfg_reg.en && lf_rise && cfg_reg.mode == MODE_FREE) |=> timer_reg == $past(timer_inc);
  endproperty
  a_wrap: assert property (p_wrap) else $error("mode 10 did not count on");

  property p_wake_first;
    @(posedge hclk) disable iff (!hresetn)
    $rose(tick_reg) |-> $past(wake_reg, 2);
  endproperty
  a_wake_first: assert property (p_wake_first) else $error("tick before wake");

  property p_off_ground;
    @(posedge hclk) disable iff (!hresetn)
    !cfg_reg.en |=> !tick_reg && !wake_reg && $stable(timer_reg);
  endproperty
  a_off_ground: assert property (p_off_ground) else $error("disabled core active");

  property p_count;
    @(posedge hclk) disable iff (!hresetn)
    (cfg_reg.en && lf_rise && cfg_reg.mode != MODE_CLEAR) |=> timer_reg == $past(timer_reg) + 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("timer missed an lf edge");

endmodule // lptt_top

`default_nettype wire

// ==== hw/lptt_pkg.sv ====
/*
  Shared constants and carriers of the low power tick timer with capture.
  Assumes a 50 MHz bus clock and a free 32 kHz clock arriving on a pin.
*/
package lptt_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CPT_SLOW_HIGH = 8'hab;
  localparam logic [7:0] IDX_CPT_FINE = 8'hac;
  localparam logic [7:0] IDX_CONFIG = 8'hb3;
  localparam logic [7:0] IDX_CMP_LOW = 8'hb4;
  localparam logic [7:0] IDX_CMP_HIGH = 8'hb5;
  localparam logic [7:0] IDX_CPT_SLOW_LOW = 8'hb6;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hc0;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hc1;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'hc2;

  // config field positions
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_MODE_LO = 1;
  localparam int CFG_MODE_HI = 2;
  localparam int CFG_RADIO_BIT = 3;
  localparam int CFG_SWCAP_BIT = 4;

  // compare modes
  localparam logic [1:0] MODE_FREE = 2'h2;
  localparam logic [1:0] MODE_CLEAR = 2'h3;

  // reset values
  localparam logic [7:0] CMP_RESET = 8'hff;
  localparam logic [7:0] CPT_RESET = 8'h00;

  // timing
  localparam int CLK_FREQ_HZ = 50000000;
  localparam int LF_FREQ_HZ = 32768;
  localparam int TICK_HALF_NS = 15259;
  localparam int TICK_CYC_RAW = (TICK_HALF_NS * (CLK_FREQ_HZ / 1000000)) / 1000;
  localparam int TICK_CYC = (TICK_CYC_RAW < 1) ? 1 : TICK_CYC_RAW;

  typedef struct packed {
    logic radio_en;
    logic [1:0] mode;
    logic en;
  } lptt_cfg_s;

  typedef struct packed {
    logic capture;
    logic tick;
  } lptt_irq_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RDWAIT = 2'b01
  } lptt_bus_e;

endpackage

// ==== tb/lptt_far_model.sv ====
/*
  far side of the tick timer: free running 32 kHz source and radio line.
  assumes both pins are synchronised inside the block.
*/
`timescale 1ns/100ps
`default_nettype none

module lptt_far_model #(
  parameter int LF_HALF_NS = 15259
)(
  output logic lf_clk_pin,
  output logic radio_irq_pin
);
  initial
  begin
    lf_clk_pin = 1'b0;
    radio_irq_pin = 1'b0;
  end

  always #(LF_HALF_NS) lf_clk_pin = ~lf_clk_pin;

  // pulse long enough for the synchroniser, kept off the clock edges
  task automatic pulse_radio();
    #3;
    radio_irq_pin = 1'b1;
    #200;
    radio_irq_pin = 1'b0;
  endtask
endmodule // lptt_far_model

`default_nettype wire

// ==== tb/tb_lptt_top.sv ====
/*
  self-checking bench of the tick timer: bus tasks and one task per scenario.
  assumes the far model drives the slow clock and the radio line.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_lptt_top
  import lptt_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, tick_o, wake_o, irq_o, lf_clk_pin, radio_irq_pin;
  logic [31:0] hrdata;
  int fail_count = 0;
  int compares = 0;

  always #10 hclk = ~hclk;

  lptt_far_model i_far (.lf_clk_pin(lf_clk_pin), .radio_irq_pin(radio_irq_pin));

  lptt_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .lf_clk_pin(lf_clk_pin), .radio_irq_pin(radio_irq_pin), .tick_o(tick_o),
    .wake_o(wake_o), .irq_o(irq_o));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // samples at the falling edge so the value equals what the next rise sees
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("response", {31'h0, hresp}, 32'h0);
    @(posedge hclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(idx, 1'b1, d, x);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] x;
    bus(idx, 1'b0, 32'h0, x);
    check(n, x, e);
  endtask

  // n is the cycle count waited, wk the wake level just before the tick
  task automatic wait_tick(input int lim, output int n, output logic wk);
    n = 0;
    wk = 1'b0;
    while (tick_o !== 1'b1 && n < lim)
    begin
      wk = wake_o;
      @(negedge hclk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk("cmp low", IDX_CMP_LOW, 32'hff);
    rd_chk("cmp high", IDX_CMP_HIGH, 32'hff);
    rd_chk("config", IDX_CONFIG, 32'h0);
    rd_chk("fine", IDX_CPT_FINE, 32'h0);
    wr(IDX_CPT_SLOW_LOW, 32'h5a);
    rd_chk("slow low ro", IDX_CPT_SLOW_LOW, 32'h0);
    wr(8'h10, 32'h5a);
    rd_chk("unmapped", 8'h10, 32'h0);
  endtask

  task automatic t_mode_clear();
    int n;
    int w;
    logic wk;
    wr(IDX_CMP_LOW, 32'h3);
    wr(IDX_CMP_HIGH, 32'h0);
    rd_chk("cmp low", IDX_CMP_LOW, 32'h3);
    wr(IDX_IRQ_ENABLE, 32'h1);
    wr(IDX_CONFIG, 32'h7);
    wait_tick(20000, n, wk);
    check("tick seen", {31'h0, tick_o}, 32'h1);
    check("wake before tick", {31'h0, wk}, 32'h1);
    w = 0;
    while (tick_o === 1'b1 && w < 2000)
    begin
      @(negedge hclk);
      w++;
    end
    check("tick width", w, TICK_CYC);
    check("irq", {31'h0, irq_o}, 32'h1);
    wait_tick(20000, n, wk);
    // four slow periods, the match clears the timer
    check("tick period", {31'h0, (n + w >= 6100) && (n + w <= 6107)}, 32'h1);
    repeat (2) @(posedge lf_clk_pin);
    repeat (100) @(posedge hclk);
    wr(IDX_CONFIG, 32'h17);
    rd_chk("slow low", IDX_CPT_SLOW_LOW, 32'h1);
    rd_chk("slow high", IDX_CPT_SLOW_HIGH, 32'h0);
    rd_chk("status", IDX_IRQ_STATUS, 32'h3);
    wr(IDX_IRQ_CLEAR, 32'h3);
    rd_chk("status clr", IDX_IRQ_STATUS, 32'h0);
    check("irq clr", {31'h0, irq_o}, 32'h0);
  endtask

  task automatic t_mode_free();
    int n;
    logic wk;
    wr(IDX_CONFIG, 32'h5);
    wait_tick(20000, n, wk);
    check("free tick", {31'h0, tick_o}, 32'h1);
    repeat (2) @(posedge lf_clk_pin);
    repeat (100) @(posedge hclk);
    wr(IDX_CONFIG, 32'h15);
    rd_chk("no clear", IDX_CPT_SLOW_LOW, 32'h5);
    check("irq before mask", {31'h0, irq_o}, 32'h1);
    wr(IDX_IRQ_ENABLE, 32'h0);
    // irq register follows the mask one edge late
    repeat (2) @(negedge hclk);
    check("irq masked", {31'h0, irq_o}, 32'h0);
  endtask

  task automatic t_mode_off();
    int n;
    logic wk;
    // mode 01 must disable compare as well
    wr(IDX_CONFIG, 32'h3);
    wait_tick(8000, n, wk);
    check("no tick off", n, 8000);
  endtask

  task automatic t_fine();
    logic [31:0] x;
    @(posedge lf_clk_pin);
    repeat (200) @(posedge hclk);
    wr(IDX_CONFIG, 32'h11);
    bus(IDX_CPT_FINE, 1'b0, 32'h0, x);
    check("fine mid", {31'h0, (x >= 97) && (x <= 103)}, 32'h1);
    @(posedge lf_clk_pin);
    repeat (1000) @(posedge hclk);
    wr(IDX_CONFIG, 32'h11);
    rd_chk("fine sat", IDX_CPT_FINE, 32'hff);
  endtask

  task automatic t_radio();
    wr(IDX_IRQ_ENABLE, 32'h2);
    wr(IDX_IRQ_CLEAR, 32'h3);
    i_far.pulse_radio();
    repeat (10) @(posedge hclk);
    rd_chk("radio off", IDX_IRQ_STATUS, 32'h0);
    wr(IDX_CONFIG, 32'h9);
    i_far.pulse_radio();
    repeat (10) @(posedge hclk);
    rd_chk("radio on", IDX_IRQ_STATUS, 32'h2);
    check("radio irq", {31'h0, irq_o}, 32'h1);
    wr(IDX_IRQ_CLEAR, 32'h2);
    repeat (3) @(posedge hclk);
    check("irq clear", {31'h0, irq_o}, 32'h0);
  endtask

  task automatic t_disable();
    wr(IDX_CONFIG, 32'h0);
    wr(IDX_CONFIG, 32'h10);
    rd_chk("no cap off", IDX_IRQ_STATUS, 32'h0);
    repeat (3000) @(posedge hclk);
    check("outputs low", {30'h0, tick_o, wake_o}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_mode_clear();
    t_mode_free();
    t_mode_off();
    t_fine();
    t_radio();
    t_disable();
    complete_run();
  end

  // the scenarios need about 34000 cycles
  initial
  begin
    repeat (95000) @(posedge hclk);
    fail_count++;
    complete_run();
  end
endmodule // tb_lptt_top

`default_nettype wire
